/* logic/sfr_pkg.sv */
// Purpose: constants for the special function register bank
// Assumes: 8-bit direct address, core clock 100 MHz
// Notes: offsets are direct addresses in the upper half
package sfr_pkg;
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] ADDR_PORT0 = 8'h80;
   localparam logic [7:0] ADDR_SP = 8'h81;
   localparam logic [7:0] ADDR_DPL = 8'h82;
   localparam logic [7:0] ADDR_DPH = 8'h83;
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
   localparam logic [7:0] ADDR_TIMER_MODE_SELECT = 8'h89;
   localparam logic [7:0] ADDR_TL0 = 8'h8A;
   localparam logic [7:0] ADDR_TL1 = 8'h8B;
   localparam logic [7:0] ADDR_TH0 = 8'h8C;
   localparam logic [7:0] ADDR_TH1 = 8'h8D;
   localparam logic [7:0] ADDR_PORT1 = 8'h90;
   localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
   localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'h99;
   localparam logic [7:0] ADDR_PORT2 = 8'hA0;
   localparam logic [7:0] ADDR_IE = 8'hA8;
   localparam logic [7:0] ADDR_PORT3 = 8'hB0;
   localparam logic [7:0] ADDR_IP = 8'hB8;
   localparam logic [7:0] ADDR_TIMER_TWO_CONTROL = 8'hC8;
   localparam logic [7:0] ADDR_RCAPH = 8'hCA;
   localparam logic [7:0] ADDR_RCAPL = 8'hCB;
   localparam logic [7:0] ADDR_TL2 = 8'hCC;
   localparam logic [7:0] ADDR_TH2 = 8'hCD;
   localparam logic [7:0] ADDR_PSW = 8'hD0;
   localparam logic [7:0] ADDR_ACC = 8'hE0;
   localparam logic [7:0] ADDR_B = 8'hF0;
   localparam logic [7:0] RST_PORT = 8'hFF;
   localparam logic [7:0] RST_SP = 8'h07;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // Implemented bit masks; others read 0
   localparam logic [7:0] MASK_POWER_CONTROL = 8'h8F;
   localparam logic [7:0] MASK_IE = 8'hBF;
   localparam logic [7:0] MASK_IP = 8'h3F;
   localparam logic [7:0] MASK_FULL = 8'hFF;
   // Timer-two control and PSW bank-select fields
   localparam int T2_CPRL_BIT = 0;
   localparam int T2_EXEN_BIT = 3;
   localparam int T2_EXF_BIT = 6;
   localparam int PSW_RS0_BIT = 3;
   localparam int PSW_RS1_BIT = 4;
endpackage

/* logic/sfr_bank.sv */
// Purpose: special function register bank of an 8-bit controller core
// Assumes: core drives byte and bit accesses synchronously on i_clk_sys
// Notes: timer counting and serial shifting live outside this block
`timescale 1ns/10ps
module sfr_bank
   import sfr_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Byte access
   input wire logic [7:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   // Bit access: address is byte address plus index
   input wire logic [7:0] i_bit_addr,
   input wire logic i_bit_wr,
   input wire logic i_bit_val,
   output logic o_bit_rdata,
   // Core stack, pointer and multiply helper operations
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic i_data_address_pointer_wr,
   input wire logic [15:0] i_data_address_pointer_wdata,
   input wire logic i_data_address_pointer_inc,
   input wire logic i_muldiv_wr,
   input wire logic [7:0] i_muldiv_b,
   // Peripheral side
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_byte,
   input wire logic i_t2_reload,
   input wire logic i_timer_two_external_trigger,
   // Outputs
   output logic [7:0] o_stack_top_pointer,
   output logic [15:0] o_data_address_pointer,
   output logic [7:0] o_tx_byte,
   output logic o_tx_start,
   output logic [1:0] o_bank_select,
   output logic [15:0] o_timer_two_count,
   output logic [7:0] o_accumulator_register,
   output logic [7:0] o_multiply_helper
);
   logic [7:0] regs [0:127];
   logic [7:0] rx_reg;
   logic [7:0] sp;
   logic timer_two_external_trigger_prev;
   logic [7:0] bit_byte;
   logic wr_hit;
   logic bit_hit;
   logic capture_ev;
   logic [7:0] next_rdata;
   logic [15:0] data_address_pointer_cur;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function automatic logic [7:0] impl_mask(input logic [7:0] a);
      case (a)
         ADDR_PORT0, ADDR_DPL, ADDR_DPH, ADDR_TIMER_CONTROL, ADDR_TIMER_MODE_SELECT, ADDR_TL0, ADDR_TL1,
         ADDR_TH0, ADDR_TH1, ADDR_PORT1, ADDR_SERIAL_CONTROL, ADDR_SERIAL_BUFFER, ADDR_PORT2, ADDR_PORT3,
         ADDR_TIMER_TWO_CONTROL, ADDR_RCAPH, ADDR_RCAPL, ADDR_TL2, ADDR_TH2, ADDR_PSW, ADDR_ACC,
         ADDR_B, ADDR_SP: impl_mask = MASK_FULL;
         ADDR_POWER_CONTROL: impl_mask = MASK_POWER_CONTROL;
         ADDR_IE: impl_mask = MASK_IE;
         ADDR_IP: impl_mask = MASK_IP;
         default: impl_mask = 8'h00;
      endcase
   endfunction

   assign wr_hit = i_wr && i_addr[7];
   // Bit space 80H-FFH maps to byte addresses ending in 0 or 8
   assign bit_byte = {i_bit_addr[7:3], 3'h0};
   assign bit_hit = i_bit_wr && i_bit_addr[7];
   // Live pointer value, so back-to-back increments do not see the lagging output copy
   assign data_address_pointer_cur = {regs[ADDR_DPH[6:0]], regs[ADDR_DPL[6:0]]};
   assign capture_ev = timer_two_external_trigger_prev && !i_timer_two_external_trigger
                       && regs[ADDR_TIMER_TWO_CONTROL[6:0]][T2_EXEN_BIT] && regs[ADDR_TIMER_TWO_CONTROL[6:0]][T2_CPRL_BIT];

   // ----------------------------------------
   // Trigger edge detect
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         timer_two_external_trigger_prev <= 1'b1;
      end else begin
         timer_two_external_trigger_prev <= i_timer_two_external_trigger;
      end
   end

   // ----------------------------------------
   // Stack pointer
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         sp <= RST_SP;
      end else if (wr_hit && i_addr == ADDR_SP) begin
         sp <= i_wdata;
      end else if (i_push) begin
         sp <= sp + 8'h01;
      end else if (i_pop) begin
         sp <= sp - 8'h01;
      end
   end

   // ----------------------------------------
   // Register array
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 128; gi++) begin : g_reg
         localparam logic [7:0] A = SFR_BASE | 8'(gi);
         localparam logic [7:0] M = impl_mask(A);
         if (M == 8'h00 || A == ADDR_SP) begin : g_none
            assign regs[gi] = 8'h00;
         end else begin : g_impl
            always_ff @(posedge i_clk_sys) begin
               if (!i_rst_n) begin
                  regs[gi] <= (A == ADDR_PORT0 || A == ADDR_PORT1 || A == ADDR_PORT2
                               || A == ADDR_PORT3) ? RST_PORT : RST_ZERO;
               end else if (A == ADDR_DPL && (i_data_address_pointer_wr || i_data_address_pointer_inc)) begin
                  regs[gi] <= i_data_address_pointer_wr ? i_data_address_pointer_wdata[7:0]
                              : 8'(data_address_pointer_cur + 16'h0001);
               end else if (A == ADDR_DPH && (i_data_address_pointer_wr || i_data_address_pointer_inc)) begin
                  regs[gi] <= i_data_address_pointer_wr ? i_data_address_pointer_wdata[15:8]
                              : 8'((data_address_pointer_cur + 16'h0001) >> 8);
               end else if (A == ADDR_B && i_muldiv_wr) begin
                  regs[gi] <= i_muldiv_b;
               end else if (A == ADDR_SERIAL_BUFFER && i_rx_valid) begin
                  regs[gi] <= regs[gi]; // Receive side kept separately
               end else if (capture_ev && A == ADDR_RCAPH) begin
                  regs[gi] <= regs[ADDR_TH2[6:0]];
               end else if (capture_ev && A == ADDR_RCAPL) begin
                  regs[gi] <= regs[ADDR_TL2[6:0]];
               end else if (capture_ev && A == ADDR_TIMER_TWO_CONTROL) begin
                  regs[gi] <= regs[gi] | (8'h01 << T2_EXF_BIT);
               end else if (i_t2_reload && !regs[ADDR_TIMER_TWO_CONTROL[6:0]][T2_CPRL_BIT] && A == ADDR_TH2) begin
                  regs[gi] <= regs[ADDR_RCAPH[6:0]];
               end else if (i_t2_reload && !regs[ADDR_TIMER_TWO_CONTROL[6:0]][T2_CPRL_BIT] && A == ADDR_TL2) begin
                  regs[gi] <= regs[ADDR_RCAPL[6:0]];
               end else if (wr_hit && i_addr == A) begin
                  regs[gi] <= i_wdata & M;
               end else if (bit_hit && bit_byte == A && A[2:0] == 3'h0) begin
                  regs[gi][i_bit_addr[2:0]] <= i_bit_val & M[i_bit_addr[2:0]];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Serial receive and transmit
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         rx_reg <= RST_ZERO;
      end else if (i_rx_valid) begin
         rx_reg <= i_rx_byte;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_tx_start <= 1'b0;
         o_tx_byte <= RST_ZERO;
      end else begin
         o_tx_start <= wr_hit && i_addr == ADDR_SERIAL_BUFFER;
         if (wr_hit && i_addr == ADDR_SERIAL_BUFFER) begin
            o_tx_byte <= i_wdata;
         end
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      if (!i_addr[7]) begin
         next_rdata = 8'h00;
      end else if (i_addr == ADDR_SP) begin
         next_rdata = sp;
      end else if (i_addr == ADDR_SERIAL_BUFFER) begin
         next_rdata = rx_reg;
      end else begin
         next_rdata = regs[i_addr[6:0]];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_rdata <= RST_ZERO;
         o_bit_rdata <= 1'b0;
      end else begin
         if (i_rd) begin
            o_rdata <= next_rdata;
         end
         o_bit_rdata <= i_bit_addr[7] ? regs[bit_byte[6:0]][i_bit_addr[2:0]] : 1'b0;
      end
   end

   // ----------------------------------------
   // Registered views
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_stack_top_pointer <= RST_SP;
         o_data_address_pointer <= {RST_ZERO, RST_ZERO};
         o_bank_select <= 2'h0;
         o_timer_two_count <= {RST_ZERO, RST_ZERO};
         o_accumulator_register <= RST_ZERO;
         o_multiply_helper <= RST_ZERO;
      end else begin
         o_stack_top_pointer <= sp;
         o_data_address_pointer <= {regs[ADDR_DPH[6:0]], regs[ADDR_DPL[6:0]]};
         o_bank_select <= {regs[ADDR_PSW[6:0]][PSW_RS1_BIT], regs[ADDR_PSW[6:0]][PSW_RS0_BIT]};
         o_timer_two_count <= {regs[ADDR_TH2[6:0]], regs[ADDR_TL2[6:0]]};
         o_accumulator_register <= regs[ADDR_ACC[6:0]];
         o_multiply_helper <= regs[ADDR_B[6:0]];
      end
   end
endmodule // sfr_bank

/* sim/sfr_bank_properties.sv */
// Purpose: port checks for sfr_bank
// Assumes: one clock, synchronous active-low reset
// Notes: outputs lag their registers by one edge
`timescale 1ns/10ps
module sfr_bank_chk
   import sfr_pkg::*;
(
   // Inputs watched
   input wire logic i_clk_sys, i_rst_n, i_wr, i_rd, i_push, i_pop, i_data_address_pointer_wr, i_muldiv_wr, i_rx_valid,
   input wire logic [7:0] i_addr, i_wdata, i_muldiv_b, i_rx_byte,
   input wire logic [15:0] i_data_address_pointer_wdata,
   // Outputs watched
   input wire logic o_tx_start,
   input wire logic [1:0] o_bank_select,
   input wire logic [7:0] o_rdata, o_stack_top_pointer, o_tx_byte, o_multiply_helper,
   input wire logic [15:0] o_data_address_pointer
);
   // --------------------------------
   // Properties
   // --------------------------------
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   property p_tx; i_wr && i_addr == ADDR_SERIAL_BUFFER |=> o_tx_start && o_tx_byte == $past(i_wdata); endproperty
   a_tx: assert property (p_tx) else $error("no transmit start");
   property p_rst; $rose(i_rst_n) |-> o_stack_top_pointer == RST_SP && o_data_address_pointer == 16'h0000; endproperty
   a_rst: assert property (p_rst) else $error("bad reset value");
   property p_push; i_push && !i_pop && !(i_wr && i_addr == ADDR_SP)
      |-> ##2 o_stack_top_pointer == $past(o_stack_top_pointer) + 8'h01; endproperty
   a_push: assert property (p_push) else $error("push did not increment");
   property p_data_address_pointer; i_data_address_pointer_wr |-> ##2 o_data_address_pointer == $past(i_data_address_pointer_wdata, 2); endproperty
   a_data_address_pointer: assert property (p_data_address_pointer) else $error("pointer load lost");
   property p_bank; i_wr && i_addr == ADDR_PSW |-> ##2 {3'b000, o_bank_select, 3'b000} == ($past(i_wdata, 2) & 8'h18);
   endproperty
   a_bank: assert property (p_bank) else $error("bank select wrong");
   property p_mul; i_muldiv_wr |-> ##2 o_multiply_helper == $past(i_muldiv_b, 2); endproperty
   a_mul: assert property (p_mul) else $error("helper load lost");
   property p_rx; i_rx_valid ##1 !i_rx_valid ##1 (i_rd && i_addr == ADDR_SERIAL_BUFFER && !i_rx_valid)
      |=> o_rdata == $past(i_rx_byte, 3); endproperty
   a_rx: assert property (p_rx) else $error("receive byte not read");
   property p_hole; i_rd && i_addr == 8'h84 |=> o_rdata == 8'h00; endproperty
   a_hole: assert property (p_hole) else $error("unmapped read not zero");
endmodule // sfr_bank_chk
bind sfr_bank sfr_bank_chk u_chk (.*);

/* sim/sfr_bank_test.sv */
// Purpose: directed bench for sfr_bank
// Assumes: inputs change on the falling edge
// Notes: fixed waits follow the hand-over latencies
`timescale 1ns/10ps
module sfr_bank_test
   import sfr_pkg::*;
();
   logic i_clk_sys, i_rst_n, i_wr, i_rd, i_bit_wr, i_bit_val, i_push, i_pop, i_data_address_pointer_wr, i_data_address_pointer_inc;
   logic i_muldiv_wr, i_rx_valid, i_t2_reload, i_timer_two_external_trigger, o_bit_rdata, o_tx_start;
   logic [7:0] i_addr, i_wdata, i_bit_addr, i_muldiv_b, i_rx_byte, o_rdata, o_stack_top_pointer, o_tx_byte;
   logic [7:0] o_accumulator_register, o_multiply_helper;
   logic [15:0] i_data_address_pointer_wdata, o_data_address_pointer, o_timer_two_count;
   logic [1:0] o_bank_select;
   int err_total, compares;
   logic [7:0] map [22] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h90,
      8'h98, 8'hA0, 8'hB0, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hE0, 8'hF0, 8'hD0};
   sfr_bank dut (.*);
   // --------------------------------
   // Access tasks
   // --------------------------------
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      compares++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge i_clk_sys);
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_clk_sys);
      i_wr = 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(negedge i_clk_sys);
      i_addr = a;
      i_rd = 1'b1;
      @(negedge i_clk_sys);
      i_rd = 1'b0;
      chk($sformatf("rdata_%h", a), e, o_rdata);
   endtask
   task automatic pulse(ref logic s);
      @(negedge i_clk_sys);
      s = 1'b1;
      @(negedge i_clk_sys);
      s = 1'b0;
   endtask
   task automatic report_and_stop();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   // --------------------------------
   // Tests
   // --------------------------------
   initial begin
      {i_rst_n, i_wr, i_rd, i_bit_wr, i_bit_val, i_push, i_pop, i_data_address_pointer_wr, i_data_address_pointer_inc} = '0;
      {i_muldiv_wr, i_rx_valid, i_t2_reload, i_addr, i_wdata, i_bit_addr, i_muldiv_b, i_rx_byte} = '0;
      i_data_address_pointer_wdata = 16'h0000;
      i_timer_two_external_trigger = 1'b1;
      err_total = 0;
      compares = 0;
      repeat (3) @(negedge i_clk_sys);
      i_rst_n = 1'b1;
      foreach (map[i]) rd(map[i], (map[i][7:6] == 2'b10 && map[i][3:0] == 4'h0) ? RST_PORT :
         (map[i] == ADDR_SP ? RST_SP : RST_ZERO));
      for (int i = 0; i < 21; i++) begin
         wr(map[i], map[i] ^ 8'hA5);
         rd(map[i], map[i] ^ 8'hA5);
      end
      $display("test reset_and_rw finished");
      wr(ADDR_ACC, 8'h3C);
      wr(8'h60, 8'hC3);
      wr(8'h84, 8'h00);
      rd(ADDR_ACC, 8'h3C);
      chk("acc", 16'h003C, o_accumulator_register);
      rd(8'h84, 8'h00);
      rd(ADDR_PORT0, 8'h25);
      rd(ADDR_POWER_CONTROL, 8'h00);
      wr(ADDR_SERIAL_BUFFER, 8'h55);
      chk("tx_start", 16'h0001, o_tx_start);
      chk("tx_byte", 16'h0055, o_tx_byte);
      i_rx_byte = 8'hC3;
      pulse(i_rx_valid);
      rd(ADDR_SERIAL_BUFFER, 8'hC3);
      $display("test decode_and_serial finished");
      wr(ADDR_SP, 8'hFF);
      pulse(i_push);
      rd(ADDR_SP, 8'h00);
      pulse(i_pop);
      rd(ADDR_SP, 8'hFF);
      i_data_address_pointer_wdata = 16'h12FF;
      pulse(i_data_address_pointer_wr);
      pulse(i_data_address_pointer_inc);
      rd(ADDR_DPH, 8'h13);
      rd(ADDR_DPL, 8'h00);
      wr(ADDR_DPH, 8'hAB);
      @(negedge i_clk_sys);
      chk("data_address_pointer", 16'hAB00, o_data_address_pointer);
      i_muldiv_b = 8'h9A;
      pulse(i_muldiv_wr);
      rd(ADDR_B, 8'h9A);
      $display("test pointers finished");
      wr(ADDR_ACC, 8'h00);
      i_bit_addr = 8'hE3;
      i_bit_val = 1'b1;
      pulse(i_bit_wr);
      @(negedge i_clk_sys);
      chk("bit", 16'h0001, o_bit_rdata);
      rd(ADDR_ACC, 8'h08);
      i_bit_addr = 8'hD4;
      pulse(i_bit_wr);
      @(negedge i_clk_sys);
      chk("bank", 16'h0002, o_bank_select);
      wr(ADDR_PSW, 8'h08);
      @(negedge i_clk_sys);
      chk("bank", 16'h0001, o_bank_select);
      $display("test bits finished");
      wr(ADDR_TIMER_TWO_CONTROL, 8'h09);
      wr(ADDR_TH2, 8'hAB);
      wr(ADDR_TL2, 8'hCD);
      i_timer_two_external_trigger = 1'b0;
      repeat (3) @(negedge i_clk_sys);
      rd(ADDR_RCAPH, 8'hAB);
      rd(ADDR_RCAPL, 8'hCD);
      wr(ADDR_TIMER_TWO_CONTROL, 8'h00);
      wr(ADDR_RCAPH, 8'h12);
      wr(ADDR_RCAPL, 8'h34);
      pulse(i_t2_reload);
      @(negedge i_clk_sys);
      chk("t2_count", 16'h1234, o_timer_two_count);
      $display("test timer_two finished");
      report_and_stop();
   end
endmodule // sfr_bank_test
